// >>> irq_pkg.sv
// constants for the interrupt controller
`default_nettype none
package irq_pkg;
    localparam int NUM_SRC = 5;
    localparam int PC_W = 11;
    localparam int STACK_DEPTH = 6;
    localparam int LEVEL_W = 3;
    // source indices, in priority order
    localparam int SRC_EXT = 0;
    localparam int SRC_T0 = 1;
    localparam int SRC_T1 = 2;
    localparam int SRC_CONV = 3;
    localparam int SRC_NVM = 4;
    // register offsets
    localparam logic [3:0] OFS_CTRL0 = 4'h0;
    localparam logic [3:0] OFS_CTRL1 = 4'h1;
    localparam logic [3:0] OFS_MISC = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;
    // irq_ctrl_reg0 fields
    localparam int C0_EMI = 0;
    localparam int C0_EN_LO = 1;
    localparam int C0_FLAG_LO = 4;
    // irq_ctrl_reg1 fields
    localparam int C1_EN_LO = 0;
    localparam int C1_FLAG_LO = 4;
    // misc fields
    localparam int MISC_EDGE_LO = 0;
    localparam int MISC_CMP_LO = 2;
    // reset values
    localparam logic [7:0] RST_CTRL0 = 8'h00;
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_MISC = 8'h00;
    // edge-select codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // vectors
    localparam logic [7:0] VEC_EXT = 8'h04;
    localparam logic [7:0] VEC_T0 = 8'h08;
    localparam logic [7:0] VEC_T1 = 8'h0C;
    localparam logic [7:0] VEC_CONV = 8'h10;
    localparam logic [7:0] VEC_NVM = 8'h14;
endpackage : irq_pkg
`default_nettype wire

// >>> stack_if.sv
// carrier between the controller and its return-address stack
`default_nettype none
interface stack_if #(parameter int PC_W = 11, parameter int LEVEL_W = 3);
    logic push;
    logic pop;
    logic [PC_W-1:0] push_pc;
    logic [PC_W-1:0] top_pc;
    logic full;
    logic empty;
    logic [LEVEL_W-1:0] level;
    modport ctrl (output push, output pop, output push_pc, input top_pc, input full, input empty, input level);
    modport store (input push, input pop, input push_pc, output top_pc, output full, output empty, output level);
endinterface : stack_if
`default_nettype wire

// >>> pc_stack.sv
// return-address stack for calls and interrupt entry
`default_nettype none
module pc_stack
    import irq_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    stack_if.store stk
);
    logic [PC_W-1:0] mem_q [DEPTH];
    logic [LEVEL_W-1:0] sp_q;
    logic [LEVEL_W-1:0] top_idx;

    assign stk.full = (sp_q == LEVEL_W'(DEPTH));
    assign stk.empty = (sp_q == '0);
    assign stk.level = sp_q;
    assign top_idx = stk.empty ? '0 : sp_q - LEVEL_W'(1);
    assign stk.top_pc = mem_q[top_idx];

    // pushes when full and pops when empty are dropped; push wins a clash
    always_ff @(posedge clk) begin
        if (reset) begin
            sp_q <= '0;
        end else if (stk.push && !stk.full) begin
            sp_q <= sp_q + LEVEL_W'(1);
        end else if (stk.pop && !stk.empty) begin
            sp_q <= sp_q - LEVEL_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (stk.push && !stk.full) begin
            mem_q[sp_q] <= stk.push_pc;
        end
    end
endmodule : pc_stack
`default_nettype wire

// >>> irq_controller.sv
// vectored interrupt controller with return stack
`default_nettype none
module irq_controller
    import irq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic port_a_pin5,
    input wire logic port_a_dir_bit5,
    input wire logic pull_high_opt,
    output logic pa5_pull_high_en,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic conv_done,
    input wire logic nvm_write_done,
    input wire logic phase_two_pulse,
    input wire logic [PC_W-1:0] core_pc,
    input wire logic sub_call,
    input wire logic sub_ret,
    output logic irq_call,
    output logic [7:0] irq_vector,
    output logic [PC_W-1:0] return_pc,
    output logic return_valid,
    output logic stack_full,
    output logic wake_req,
    output logic [5:0] cmp_ctrl
);
    typedef logic [NUM_SRC-1:0] src_t;

    src_t flag_q;
    src_t flag_d;
    src_t en_q;
    src_t event_v;
    src_t pend;
    logic global_irq_enable_q;
    logic [1:0] edge_sel_q;
    logic [5:0] cmp_q;
    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_prev_q;
    logic rise;
    logic fall;
    logic ext_active;
    logic service;
    logic [2:0] sel;
    logic wr_ctrl0;
    logic wr_ctrl1;
    logic wr_misc;
    logic [7:0] rd_d;

    stack_if #(.PC_W(PC_W), .LEVEL_W(LEVEL_W)) stk ();

    pc_stack #(.DEPTH(STACK_DEPTH)) u_stack (
        .clk(clk),
        .reset(reset),
        .stk(stk)
    );

    function automatic logic [2:0] first_pending(input src_t p);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : first_pending

    function automatic logic [7:0] vector_of(input logic [2:0] idx);
        case (idx)
            3'h0: vector_of = VEC_EXT;
            3'h1: vector_of = VEC_T0;
            3'h2: vector_of = VEC_T1;
            3'h3: vector_of = VEC_CONV;
            default: vector_of = VEC_NVM;
        endcase
    endfunction : vector_of

    assign wr_ctrl0 = reg_wr && (reg_addr == OFS_CTRL0);
    assign wr_ctrl1 = reg_wr && (reg_addr == OFS_CTRL1);
    assign wr_misc = reg_wr && (reg_addr == OFS_MISC);

    // two-stage pin synchroniser, edges on the stable copy
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
            pin_prev_q <= 1'b1;
        end else begin
            pin_meta_q <= port_a_pin5;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    assign rise = pin_sync_q && !pin_prev_q;
    assign fall = !pin_sync_q && pin_prev_q;

    // pin acts only when enabled and set as input
    assign ext_active = en_q[SRC_EXT] && port_a_dir_bit5;

    // edge type chosen by select bits
    always_comb begin
        event_v = '0;
        case (edge_sel_q)
            EDGE_FALL: event_v[SRC_EXT] = ext_active && fall;
            EDGE_RISE: event_v[SRC_EXT] = ext_active && rise;
            EDGE_BOTH: event_v[SRC_EXT] = ext_active && (rise || fall);
            default: event_v[SRC_EXT] = 1'b0;
        endcase
        event_v[SRC_T0] = timer0_overflow;
        event_v[SRC_T1] = timer1_overflow;
        event_v[SRC_CONV] = conv_done;
        event_v[SRC_NVM] = nvm_write_done;
    end

    // global and per-source enables gate service
    assign pend = flag_q & en_q;
    assign sel = first_pending(pend);
    // taken only on the phase pulse; blocked while stack full
    assign service = phase_two_pulse && global_irq_enable_q && (|pend) && !stk.full;

    // flags hold until served or written; hardware set beats any clear
    always_comb begin
        flag_d = flag_q;
        if (wr_ctrl0) begin
            flag_d[2:0] = reg_wdata[C0_FLAG_LO +: 3];
        end
        if (wr_ctrl1) begin
            flag_d[4:3] = reg_wdata[C1_FLAG_LO +: 2];
        end
        if (service) begin
            flag_d[sel] = 1'b0;
        end
        flag_d = flag_d | event_v;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // enables; entry clear of the global enable overrides a same-cycle write
    always_ff @(posedge clk) begin
        if (reset) begin
            global_irq_enable_q <= RST_CTRL0[C0_EMI];
            en_q <= '0;
        end else begin
            if (wr_ctrl0) begin
                global_irq_enable_q <= reg_wdata[C0_EMI];
                en_q[2:0] <= reg_wdata[C0_EN_LO +: 3];
            end
            if (wr_ctrl1) begin
                en_q[4:3] <= reg_wdata[C1_EN_LO +: 2];
            end
            if (service) begin
                global_irq_enable_q <= 1'b0;
            end
        end
    end

    // comparator bits kept as written; software must merge them
    always_ff @(posedge clk) begin
        if (reset) begin
            edge_sel_q <= RST_MISC[MISC_EDGE_LO +: 2];
            cmp_q <= RST_MISC[MISC_CMP_LO +: 6];
        end else if (wr_misc) begin
            edge_sel_q <= reg_wdata[MISC_EDGE_LO +: 2];
            cmp_q <= reg_wdata[MISC_CMP_LO +: 6];
        end
    end

    assign cmp_ctrl = cmp_q;

    // entry pushes pc; the core must not call in the same cycle
    assign stk.push = service || sub_call;
    assign stk.push_pc = core_pc;
    assign stk.pop = sub_ret && !stk.push;
    assign stack_full = stk.full;

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_call <= 1'b0;
            irq_vector <= '0;
        end else begin
            irq_call <= service;
            if (service) begin
                irq_vector <= vector_of(sel);
            end
        end
    end

    // resume address one cycle after the pop
    always_ff @(posedge clk) begin
        if (reset) begin
            return_valid <= 1'b0;
            return_pc <= '0;
        end else begin
            return_valid <= stk.pop && !stk.empty;
            if (stk.pop && !stk.empty) begin
                return_pc <= stk.top_pc;
            end
        end
    end

    // any raised flag wakes the core, enabled or not
    always_ff @(posedge clk) begin
        if (reset) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= |flag_q;
        end
    end

    // pull-high follows the option while the pin is an input, regardless of interrupt use
    always_ff @(posedge clk) begin
        if (reset) begin
            pa5_pull_high_en <= 1'b0;
        end else begin
            pa5_pull_high_en <= pull_high_opt && port_a_dir_bit5;
        end
    end

    always_comb begin
        rd_d = 8'h00;
        case (reg_addr)
            OFS_CTRL0: begin
                rd_d[C0_EMI] = global_irq_enable_q;
                rd_d[C0_EN_LO +: 3] = en_q[2:0];
                rd_d[C0_FLAG_LO +: 3] = flag_q[2:0];
            end
            OFS_CTRL1: begin
                rd_d[C1_EN_LO +: 2] = en_q[4:3];
                rd_d[C1_FLAG_LO +: 2] = flag_q[4:3];
            end
            OFS_MISC: begin
                rd_d[MISC_EDGE_LO +: 2] = edge_sel_q;
                rd_d[MISC_CMP_LO +: 6] = cmp_q;
            end
            OFS_STATUS: begin
                rd_d[LEVEL_W-1:0] = stk.level;
                rd_d[LEVEL_W] = stk.full;
            end
            default: rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence entry_s;
        service ##1 irq_call;
    endsequence

    sequence ext_fall_s;
        ext_active && (edge_sel_q == EDGE_FALL) && fall;
    endsequence

    entry_clears_emi_a: assert property (service |=> irq_call && !global_irq_enable_q)
        else $error("global enable not cleared on entry");

    // external first and vectored to 04H
    ext_vector_a: assert property (service && pend[SRC_EXT] |=> irq_vector == VEC_EXT)
        else $error("external request not vectored to 04H");

    timer_priority_a: assert property (service && !pend[SRC_EXT] && pend[SRC_T0] |=> irq_vector == VEC_T0)
        else $error("timer 0 priority or vector wrong");

    full_blocks_a: assert property (stk.full && !stk.pop |=> stk.full && !irq_call)
        else $error("entry taken with stack full");

    pulse_only_a: assert property (irq_call |-> $past(phase_two_pulse) && $past(global_irq_enable_q))
        else $error("entry outside phase pulse");

    push_level_a: assert property (entry_s |-> stk.level == $past(stk.level, 1) + LEVEL_W'(1))
        else $error("entry did not push pc");

    fall_edge_a: assert property (ext_fall_s |=> flag_q[SRC_EXT])
        else $error("falling edge lost");

    // disabled flag holds without service or write
    flag_hold_a: assert property (flag_q[SRC_T0] && !en_q[SRC_T0] && !wr_ctrl0 |=> flag_q[SRC_T0])
        else $error("pending flag dropped");

    timer_flag_a: assert property (timer0_overflow |=> flag_q[SRC_T0])
        else $error("timer 0 flag not set");

    conv_flag_a: assert property (conv_done |=> flag_q[SRC_CONV])
        else $error("converter flag not set");

    nvm_flag_a: assert property (nvm_write_done |=> flag_q[SRC_NVM])
        else $error("memory flag not set");

    // timer 1 alone goes to 0CH
    timer1_vector_a: assert property (service && pend[2:0] == 3'h4 |=> irq_vector == VEC_T1)
        else $error("timer 1 not vectored to 0CH");

    wake_flag_a: assert property (flag_q[SRC_NVM] |=> wake_req)
        else $error("no wake on pending flag");

    // return gives saved pc next cycle
    return_pop_a: assert property (stk.pop && !stk.empty |=> return_valid && return_pc == $past(stk.top_pc))
        else $error("return address not delivered");
endmodule : irq_controller
`default_nettype wire

// >>> core_model.sv
// processor core model: phase pulses, program counter, call and return
`default_nettype none
module core_model
    import irq_pkg::*;
#(
    parameter logic [PC_W-1:0] START_PC = 11'h123
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic do_call,
    input wire logic do_ret,
    input wire logic irq_call,
    input wire logic [7:0] irq_vector,
    input wire logic return_valid,
    input wire logic [PC_W-1:0] return_pc,
    output logic phase_two_pulse,
    output logic [PC_W-1:0] core_pc,
    output logic sub_call,
    output logic sub_ret
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
    assign phase_two_pulse = (phase_q == 2'h3);
    // pc held still between jumps so the pushed value is known
    always_ff @(posedge clk) begin
        if (reset) begin
            core_pc <= START_PC;
        end else if (irq_call) begin
            core_pc <= PC_W'(irq_vector);
        end else if (return_valid) begin
            core_pc <= return_pc;
        end
    end
    // call and return requests passed on one cycle later, whatever the core is running; held low in reset
    always_ff @(posedge clk) begin
        sub_call <= do_call & ~reset;
        sub_ret <= do_ret & ~reset;
    end
endmodule : core_model
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the interrupt controller
`default_nettype none
module testbench import irq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] VECS [5] = '{VEC_EXT, VEC_T0, VEC_T1, VEC_CONV, VEC_NVM};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, port_a_pin5 = 1'b1;
    logic port_a_dir_bit5 = 1'b1, pull_high_opt = 1'b1;
    logic timer0_overflow = 1'b0, timer1_overflow = 1'b0, conv_done = 1'b0, nvm_write_done = 1'b0;
    logic do_call = 1'b0, do_ret = 1'b0, last_pulse = 1'b0;
    logic [7:0] reg_rdata, irq_vector;
    logic [PC_W-1:0] core_pc, return_pc;
    logic [5:0] cmp_ctrl;
    logic pa5_pull_high_en, phase_two_pulse, sub_call, sub_ret, irq_call, return_valid, stack_full, wake_req;
    int errors = 0, checked = 0, cycles = 0;
    irq_controller uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_a_pin5,
        .port_a_dir_bit5, .pull_high_opt, .pa5_pull_high_en, .timer0_overflow, .timer1_overflow, .conv_done,
        .nvm_write_done, .phase_two_pulse, .core_pc, .sub_call, .sub_ret, .irq_call, .irq_vector, .return_pc,
        .return_valid, .stack_full, .wake_req, .cmp_ctrl);
    core_model core (.clk, .reset, .do_call, .do_ret, .irq_call, .irq_vector, .return_valid, .return_pc,
        .phase_two_pulse, .core_pc, .sub_call, .sub_ret);
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        last_pulse <= phase_two_pulse;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end
    task automatic final_report;
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string name);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, e, reg_rdata);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic events(input logic [3:0] m);
        @(posedge clk);
        {nvm_write_done, conv_done, timer1_overflow, timer0_overflow} <= m;
        @(posedge clk);
        {nvm_write_done, conv_done, timer1_overflow, timer0_overflow} <= 4'h0;
    endtask : events
    task automatic no_irq(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            chk("no irq_call", 1'b0, irq_call);
        end
    endtask : no_irq
    task automatic wait_irq(input logic [7:0] vec);
        int n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (irq_call !== 1'b1 && n < 40);
        chk("irq_call", 1'b1, irq_call);
        chk("irq_vector", vec, irq_vector);
        // entry only at a phase pulse
        chk("entry at phase pulse", 1'b1, last_pulse);
    endtask : wait_irq
    task automatic pulse(input logic ret_req);
        @(posedge clk);
        if (ret_req) begin
            do_ret <= 1'b1;
        end else begin
            do_call <= 1'b1;
        end
        @(posedge clk);
        do_ret <= 1'b0;
        do_call <= 1'b0;
    endtask : pulse
    task automatic ret(input logic [PC_W-1:0] e);
        int n = 0;
        pulse(1'b1);
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (return_valid !== 1'b1 && n < 8);
        chk("return_valid", 1'b1, return_valid);
        chk("return_pc", e, return_pc);
    endtask : ret
    initial begin
        cyc(4);
        reset <= 1'b0;
        rd(OFS_CTRL0, RST_CTRL0, "ctrl0 reset");
        rd(OFS_CTRL1, RST_CTRL1, "ctrl1 reset");
        rd(OFS_MISC, RST_MISC, "misc reset");
        rd(OFS_STATUS, 8'h00, "status reset");
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00, "unmapped");
        chk("pull-high", 1'b1, pa5_pull_high_en);
        // pin is an input and the source enabled first
        wr(OFS_CTRL0, 8'h02);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_MISC, {6'h2A, 2'(m)});
            for (int v = 0; v < 2; v++) begin
                @(posedge clk);
                port_a_pin5 <= v[0];
                cyc(5);
                rd(OFS_CTRL0, {3'h0, m[v], 4'h2}, "ext flag");
                chk("wake_req", m[v], wake_req);
                chk("cmp_ctrl", 6'h2A, cmp_ctrl);
                wr(OFS_CTRL0, 8'h02);
            end
        end
        // pin ignored while it is an output
        @(posedge clk);
        port_a_dir_bit5 <= 1'b0;
        port_a_pin5 <= 1'b0;
        cyc(5);
        chk("pull-high off", 1'b0, pa5_pull_high_en);
        @(posedge clk);
        port_a_pin5 <= 1'b1;
        cyc(5);
        rd(OFS_CTRL0, 8'h02, "pin as output");
        @(posedge clk);
        port_a_dir_bit5 <= 1'b1;
        wr(OFS_CTRL0, 8'h11);
        no_irq(12);
        wr(OFS_CTRL0, 8'h13);
        wait_irq(VEC_EXT);
        rd(OFS_CTRL0, 8'h02, "ctrl0 after entry");
        rd(OFS_STATUS, 8'h01, "level after entry");
        ret(11'h123);
        events(4'h1);
        wr(OFS_CTRL0, 8'h23);
        no_irq(12);
        rd(OFS_CTRL0, 8'h23, "flag held");
        wr(OFS_CTRL0, 8'h2E);
        wr(OFS_CTRL1, 8'h03);
        @(posedge clk);
        port_a_pin5 <= 1'b0;
        events(4'hE);
        cyc(5);
        rd(OFS_CTRL0, 8'h7E, "ctrl0 flags");
        rd(OFS_CTRL1, 8'h33, "ctrl1 flags");
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CTRL0, 8'h0F | ((8'h70 << i) & 8'h70));
            wait_irq(VECS[i]);
            ret(11'h123);
        end
        rd(OFS_CTRL1, 8'h03, "ctrl1 flags served");
        repeat (6) pulse(1'b0);
        cyc(2);
        chk("stack_full", 1'b1, stack_full);
        rd(OFS_STATUS, 8'h0E, "status full");
        events(4'h1);
        wr(OFS_CTRL0, 8'h2F);
        no_irq(12);
        rd(OFS_CTRL0, 8'h2F, "pending while full");
        ret(11'h123);
        wait_irq(VEC_T0);
        @(posedge clk);
        reset <= 1'b1;
        cyc(2);
        reset <= 1'b0;
        rd(OFS_STATUS, 8'h00, "status after reset");
        final_report();
    end
endmodule : testbench
`default_nettype wire
